// File: rtl/ucu_regs.sv
// Purpose: Clock unit register bank and clock enable generation
// Assumes: All clock sources arrive as ticks synchronous to ref_clk
// Notes: Loop tuning itself is outside; it sends up and down steps
`timescale 1ns/1ps
module ucu_regs
   import ucu_pkg::*;
#(
   parameter bit HAS_XT2 = 1'b1
)
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [4:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic byte_en,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata,
   input wire logic loop_step_up,
   input wire logic loop_step_down,
   input wire logic radio_asleep,
   input wire logic xt1_tick,
   input wire logic xt1_ext_tick,
   input wire logic vlo_tick,
   input wire logic ref_tick,
   input wire logic dco_tick,
   input wire logic xt2_tick,
   output logic [4:0] osc_tap,
   output logic [4:0] modulation_counter,
   output logic modulation_enable,
   output logic [2:0] osc_range_select,
   output logic [9:0] loop_multiplier,
   output logic loop_fb_tick,
   output logic loop_ref_tick,
   output logic aux_tick,
   output logic main_tick,
   output logic sub_tick,
   output logic aux_pin_out,
   output logic xt2_enable,
   output logic xt1_internal_enable,
   output logic [1:0] primary_crystal_drive,
   output logic [1:0] load_capacitor_apply,
   output logic primary_crystal_mode
);
   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic [15:0] tap_mod, range_ctl, loop_div, loop_ref, src_sel;
   logic [15:0] div_sel, xtal, fault, req_en, swing;
   logic [15:0] next_tap_mod;
   logic osc_fault_flag;
   logic dco_div_tick, xt1_src_tick, ref_clk_sel_tick;
   logic aux_src_tick, main_src_tick, sub_src_tick, sub_div_tick;
   logic [5:0] src_ticks;
   logic pin_tick;

   // Byte lanes: byte_en high means addr bit 0 picks one lane
   function automatic logic [15:0] lane_mask(input logic be, input logic a0);
      lane_mask = !be ? 16'hffff : (a0 ? 16'hff00 : 16'h00ff);
   endfunction : lane_mask

   // Byte write data always arrives on the low lane of wdata
   function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] wmask,
      input logic [15:0] d, input logic be, input logic a0);
      logic [15:0] m;
      logic [15:0] dd;
      m = lane_mask(be, a0) & wmask;
      dd = (be && a0) ? {d[7:0], 8'h00} : (be ? {8'h00, d[7:0]} : d);
      merge = (cur & ~m) | (dd & m);
   endfunction : merge

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      hit = ({a[4:1], 1'b0} == ofs);
   endfunction : hit

   // ------------------------------------------------------------
   // Tap and modulation, loop steps win over a write
   // ------------------------------------------------------------
   always_comb
   begin
      next_tap_mod = tap_mod;
      if (wr_en && hit(addr, OFS_TAP_MOD))
         next_tap_mod = merge(tap_mod, WM_TAP_MOD, wdata, byte_en, addr[0]);
      if (loop_step_up && !loop_step_down)
      begin
         next_tap_mod[7:3] = tap_mod[7:3] + 5'h01;
         if (tap_mod[7:3] == 5'h1f && tap_mod[12:8] != TAP_MAX)
            next_tap_mod[12:8] = tap_mod[12:8] + 5'h01;
         else
            next_tap_mod[12:8] = tap_mod[12:8];
      end
      else if (loop_step_down && !loop_step_up)
      begin
         next_tap_mod[7:3] = tap_mod[7:3] - 5'h01;
         if (tap_mod[7:3] == 5'h00 && tap_mod[12:8] != 5'h00)
            next_tap_mod[12:8] = tap_mod[12:8] - 5'h01;
         else
            next_tap_mod[12:8] = tap_mod[12:8];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         tap_mod <= RST_TAP_MOD;
      else
         tap_mod <= next_tap_mod;
   end

   // ------------------------------------------------------------
   // Plain control registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         range_ctl <= RST_RANGE;
         loop_div <= RST_LOOP_DIV;
         loop_ref <= RST_LOOP_REF;
         src_sel <= RST_SRC_SEL;
         div_sel <= RST_DIV_SEL;
         xtal <= RST_XTAL;
         req_en <= RST_REQ_EN;
         swing <= RST_SWING;
      end
      else if (wr_en)
      begin
         if (hit(addr, OFS_RANGE))
            range_ctl <= merge(range_ctl, WM_RANGE, wdata, byte_en, addr[0]);
         if (hit(addr, OFS_LOOP_DIV))
         begin
            loop_div <= merge(loop_div, WM_LOOP_DIV, wdata, byte_en, addr[0]);
            // Zero multiplier would stall the loop, store one instead
            if (merge(loop_div, WM_LOOP_DIV, wdata, byte_en, addr[0]) ==? 16'b?????_?0000000000)
               loop_div[9:0] <= MULT_MIN;
         end
         if (hit(addr, OFS_LOOP_REF))
            loop_ref <= merge(loop_ref, WM_LOOP_REF, wdata, byte_en, addr[0]);
         if (hit(addr, OFS_SRC_SEL))
            src_sel <= merge(src_sel, WM_SRC_SEL, wdata, byte_en, addr[0]);
         if (hit(addr, OFS_DIV_SEL))
            div_sel <= merge(div_sel, WM_DIV_SEL, wdata, byte_en, addr[0]);
         if (hit(addr, OFS_XTAL))
            xtal <= merge(xtal, WM_XTAL, wdata, byte_en, addr[0]);
         if (hit(addr, OFS_REQ_EN))
            req_en <= merge(req_en, WM_REQ_EN, wdata, byte_en, addr[0]) | RO_REQ_EN;
         if (hit(addr, OFS_SWING))
            swing <= merge(swing, WM_SWING, wdata, byte_en, addr[0]);
      end
   end

   // ------------------------------------------------------------
   // Fault register, tap at either end sets flag over clear
   // ------------------------------------------------------------
   assign osc_fault_flag = (tap_mod[12:8] == 5'h00) || (tap_mod[12:8] == TAP_MAX);

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         fault <= RST_FAULT;
      else
      begin
         if (wr_en && hit(addr, OFS_FAULT))
            fault <= merge(fault, WM_FAULT, wdata, byte_en, addr[0]) | RO_FAULT;
         if (osc_fault_flag)
            fault[POS_OSC_FAULT] <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         rdata <= 16'h0000;
      else if (rd_en)
      begin
         unique case ({addr[4:1], 1'b0})
            OFS_TAP_MOD: rdata <= tap_mod & lane_mask(byte_en, addr[0]);
            OFS_RANGE: rdata <= range_ctl & lane_mask(byte_en, addr[0]);
            OFS_LOOP_DIV: rdata <= loop_div & lane_mask(byte_en, addr[0]);
            OFS_LOOP_REF: rdata <= loop_ref & lane_mask(byte_en, addr[0]);
            OFS_SRC_SEL: rdata <= src_sel & lane_mask(byte_en, addr[0]);
            OFS_DIV_SEL: rdata <= div_sel & lane_mask(byte_en, addr[0]);
            OFS_XTAL: rdata <= xtal & lane_mask(byte_en, addr[0]);
            OFS_FAULT: rdata <= fault & lane_mask(byte_en, addr[0]);
            OFS_REQ_EN: rdata <= req_en & lane_mask(byte_en, addr[0]);
            OFS_SWING: rdata <= swing & lane_mask(byte_en, addr[0]);
            default: rdata <= 16'h0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Oscillator control outputs
   // ------------------------------------------------------------
   assign osc_tap = tap_mod[12:8];
   assign modulation_counter = tap_mod[7:3];
   assign modulation_enable = !range_ctl[POS_MOD_DIS];
   assign osc_range_select = range_ctl[6:4];
   assign loop_multiplier = loop_div[9:0];
   // Radio in use keeps crystal 2 running regardless of the off bit
   assign xt2_enable = HAS_XT2 && !(xtal[POS_XT2_OFF] && radio_asleep);
   assign primary_crystal_drive = xtal[7:6];
   assign primary_crystal_mode = xtal[POS_XT_MODE];
   assign load_capacitor_apply = xtal[POS_XT_MODE] ? 2'h0 : xtal[3:2];
   assign xt1_internal_enable = !xtal[POS_BYPASS];
   assign xt1_src_tick = xtal[POS_BYPASS] ? xt1_ext_tick : xt1_tick;

   // ------------------------------------------------------------
   // Loop dividers
   // ------------------------------------------------------------
   always_comb
   begin
      unique case (loop_ref[6:4])
         3'h0, 3'h1: ref_clk_sel_tick = xt1_src_tick;
         3'h2, 3'h3, 3'h4: ref_clk_sel_tick = ref_tick;
         default: ref_clk_sel_tick = HAS_XT2 ? xt2_tick : ref_tick;
      endcase
   end

   ucu_pow_div u_fb_div (
      .ref_clk(ref_clk), .resetn(resetn), .code(loop_div[14:12]),
      .tick_in(dco_tick), .tick_out(loop_fb_tick));

   // Reference divider has a /12 step, so it needs its own counter
   logic [3:0] ref_cnt;
   logic [3:0] ref_lim;
   always_comb
   begin
      unique case (loop_ref[2:0])
         3'h0: ref_lim = 4'h0;
         3'h1: ref_lim = 4'h1;
         3'h2: ref_lim = 4'h3;
         3'h3: ref_lim = 4'h7;
         3'h4: ref_lim = 4'hb;
         default: ref_lim = 4'hf;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         ref_cnt <= 4'h0;
      else if (ref_clk_sel_tick)
         ref_cnt <= (ref_cnt >= ref_lim) ? 4'h0 : ref_cnt + 4'h1;
   end
   assign loop_ref_tick = ref_clk_sel_tick && (ref_cnt >= ref_lim);

   // Divided oscillator: fixed /2 of the raw oscillator ticks
   logic dco_half;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         dco_half <= 1'b0;
      else if (dco_tick)
         dco_half <= !dco_half;
   end
   assign dco_div_tick = dco_tick && dco_half;

   // ------------------------------------------------------------
   // System clock selection and division
   // ------------------------------------------------------------
   assign src_ticks = {xt2_tick, dco_div_tick, dco_tick, ref_tick, vlo_tick, xt1_src_tick};

   ucu_src_mux #(.HAS_XT2(HAS_XT2)) u_aux_mux (
      .sel(src_sel[10:8]), .src_ticks(src_ticks), .tick(aux_src_tick));
   ucu_src_mux #(.HAS_XT2(HAS_XT2)) u_sub_mux (
      .sel(src_sel[6:4]), .src_ticks(src_ticks), .tick(sub_src_tick));
   ucu_src_mux #(.HAS_XT2(HAS_XT2)) u_main_mux (
      .sel(src_sel[2:0]), .src_ticks(src_ticks), .tick(main_src_tick));

   ucu_pow_div u_aux_div (
      .ref_clk(ref_clk), .resetn(resetn), .code(div_sel[10:8]),
      .tick_in(aux_src_tick), .tick_out(aux_tick));
   ucu_pow_div u_sub_div (
      .ref_clk(ref_clk), .resetn(resetn), .code(div_sel[6:4]),
      .tick_in(sub_src_tick), .tick_out(sub_div_tick));
   ucu_pow_div u_main_div (
      .ref_clk(ref_clk), .resetn(resetn), .code(div_sel[2:0]),
      .tick_in(main_src_tick), .tick_out(main_tick));
   ucu_pow_div u_pin_div (
      .ref_clk(ref_clk), .resetn(resetn), .code(div_sel[14:12]),
      .tick_in(aux_tick), .tick_out(pin_tick));

   assign sub_tick = sub_div_tick && !xtal[POS_SUB_GATE];

   // Pin output toggles per divided tick, so its period is twice the tick spacing
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         aux_pin_out <= 1'b0;
      else if (pin_tick)
         aux_pin_out <= !aux_pin_out;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_tap_roll_up: assert property (@(posedge ref_clk) disable iff (!resetn)
      loop_step_up && !loop_step_down && tap_mod[7:3] == 5'h1f && tap_mod[12:8] != 5'h1f
      |=> osc_tap == $past(osc_tap) + 5'h01 && modulation_counter == 5'h00)
      else $error("tap not incremented on modulation rollover");

   a_tap_roll_down: assert property (@(posedge ref_clk) disable iff (!resetn)
      loop_step_down && !loop_step_up && tap_mod[7:3] == 5'h00 && tap_mod[12:8] != 5'h00
      |=> osc_tap == $past(osc_tap) - 5'h01 && modulation_counter == 5'h1f)
      else $error("tap not decremented on modulation wrap");

   a_mult_nonzero: assert property (@(posedge ref_clk) disable iff (!resetn)
      loop_multiplier != 10'h000)
      else $error("multiplier stored as zero");

   a_fault_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      osc_fault_flag |=> fault[POS_OSC_FAULT])
      else $error("fault flag missed tap end");

   a_sub_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      xtal[POS_SUB_GATE] |-> !sub_tick)
      else $error("subsystem clock ran while gated");

   a_xt2_off: assert property (@(posedge ref_clk) disable iff (!resetn)
      !xtal[POS_XT2_OFF] |-> xt2_enable == HAS_XT2)
      else $error("crystal 2 stopped while on");

   a_cap_hf: assert property (@(posedge ref_clk) disable iff (!resetn)
      primary_crystal_mode |-> load_capacitor_apply == 2'h0)
      else $error("capacitors applied in high-frequency mode");

   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_en && hit(addr, OFS_TAP_MOD) |=> (rdata & 16'he007) == 16'h0000)
      else $error("reserved bits read nonzero");

   a_write_store: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_en && !byte_en && hit(addr, OFS_DIV_SEL) |=> div_sel == ($past(wdata) & WM_DIV_SEL))
      else $error("word write not stored");

endmodule : ucu_regs

// File: rtl/ucu_pkg.sv
// Purpose: Shared constants for the clock unit register bank
// Assumes: 16-bit registers at byte offsets, word and byte access
// Notes: Field positions are the low bit of each field
package ucu_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [4:0] OFS_TAP_MOD = 5'h00;
   localparam logic [4:0] OFS_RANGE = 5'h02;
   localparam logic [4:0] OFS_LOOP_DIV = 5'h04;
   localparam logic [4:0] OFS_LOOP_REF = 5'h06;
   localparam logic [4:0] OFS_SRC_SEL = 5'h08;
   localparam logic [4:0] OFS_DIV_SEL = 5'h0a;
   localparam logic [4:0] OFS_XTAL = 5'h0c;
   localparam logic [4:0] OFS_FAULT = 5'h0e;
   localparam logic [4:0] OFS_REQ_EN = 5'h10;
   localparam logic [4:0] OFS_SWING = 5'h12;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_TAP_MOD = 16'h0000;
   localparam logic [15:0] RST_RANGE = 16'h0020;
   localparam logic [15:0] RST_LOOP_DIV = 16'h101f;
   localparam logic [15:0] RST_LOOP_REF = 16'h0000;
   localparam logic [15:0] RST_SRC_SEL = 16'h0044;
   localparam logic [15:0] RST_DIV_SEL = 16'h0000;
   localparam logic [15:0] RST_XTAL = 16'hc1cd;
   localparam logic [15:0] RST_FAULT = 16'h0703;
   localparam logic [15:0] RST_REQ_EN = 16'h0707;
   localparam logic [15:0] RST_SWING = 16'h0000;

   // ------------------------------------------------------------
   // Writable bit masks, reserved read-only bits are zero
   // ------------------------------------------------------------
   localparam logic [15:0] WM_TAP_MOD = 16'h1ff8;
   localparam logic [15:0] WM_RANGE = 16'h0073;
   localparam logic [15:0] WM_LOOP_DIV = 16'h73ff;
   localparam logic [15:0] WM_LOOP_REF = 16'h0077;
   localparam logic [15:0] WM_SRC_SEL = 16'h0777;
   localparam logic [15:0] WM_DIV_SEL = 16'h7777;
   localparam logic [15:0] WM_XTAL = 16'h01ff;
   localparam logic [15:0] WM_FAULT = 16'h3c1f;
   localparam logic [15:0] WM_REQ_EN = 16'h000f;
   localparam logic [15:0] WM_SWING = 16'h0003;
   localparam logic [15:0] RO_FAULT = 16'h0300;
   localparam logic [15:0] RO_REQ_EN = 16'h0700;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int POS_TAP = 8;
   localparam int POS_MOD = 3;
   localparam int POS_RANGE = 4;
   localparam int POS_MOD_DIS = 0;
   localparam int POS_FB_DIV = 12;
   localparam int POS_MULT = 0;
   localparam int POS_REF_SEL = 4;
   localparam int POS_REF_DIV = 0;
   localparam int POS_AUX = 8;
   localparam int POS_SUB = 4;
   localparam int POS_MAIN = 0;
   localparam int POS_PIN_DIV = 12;
   localparam int POS_XT2_OFF = 8;
   localparam int POS_DRIVE = 6;
   localparam int POS_XT_MODE = 5;
   localparam int POS_BYPASS = 4;
   localparam int POS_CAP = 2;
   localparam int POS_SUB_GATE = 1;
   localparam int POS_OSC_FAULT = 0;

   localparam logic [4:0] TAP_MAX = 5'h1f;
   localparam logic [9:0] MULT_MIN = 10'h001;

   typedef enum logic [2:0] {
      SRC_XT1, SRC_VLO, SRC_REF, SRC_DCO, SRC_DCO_DIV, SRC_XT2
   } ucu_src_type;

endpackage : ucu_pkg

// File: rtl/ucu_pow_div.sv
// Purpose: Power-of-two clock enable divider, /1 to /32
// Assumes: Single ref_clk, input enable marks source clock ticks
// Notes: Codes above 101b saturate at /32
`timescale 1ns/1ps
module ucu_pow_div
   import ucu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [2:0] code,
   input wire logic tick_in,
   output logic tick_out
);
   logic [4:0] count;
   logic [4:0] limit;

   always_comb
   begin
      limit = (code >= 3'h5) ? 5'h1f : 5'((5'h01 << code) - 5'h01);
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         count <= 5'h00;
      else if (tick_in)
         count <= (count >= limit) ? 5'h00 : count + 5'h01;
   end

   // Combinational so /1 passes each input tick straight through
   assign tick_out = tick_in && (count >= limit);

endmodule : ucu_pow_div

// File: rtl/ucu_src_mux.sv
// Purpose: System clock source selection from a three-bit code
// Assumes: Sources are enable ticks on ref_clk
// Notes: Crystal 2 absence falls back to divided oscillator
`timescale 1ns/1ps
module ucu_src_mux
   import ucu_pkg::*;
#(
   parameter bit HAS_XT2 = 1'b1
)
(
   input wire logic [2:0] sel,
   input wire logic [5:0] src_ticks,
   output logic tick
);
   always_comb
   begin
      unique case (sel)
         3'h0: tick = src_ticks[SRC_XT1];
         3'h1: tick = src_ticks[SRC_VLO];
         3'h2: tick = src_ticks[SRC_REF];
         3'h3: tick = src_ticks[SRC_DCO];
         3'h4: tick = src_ticks[SRC_DCO_DIV];
         default: tick = HAS_XT2 ? src_ticks[SRC_XT2] : src_ticks[SRC_DCO_DIV];
      endcase
   end

endmodule : ucu_src_mux

// File: tb/tb_ucu_regs.sv
// Purpose: Self-checking bench for the clock unit register bank
// Assumes: Source ticks come from one free cycle counter
// Notes: Tick counts allow one count of phase slack
`timescale 1ns/1ps
module tb_ucu_regs;
   import ucu_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic wr_en = 1'b0, rd_en = 1'b0, byte_en = 1'b0, up = 1'b0, dn = 1'b0, asl = 1'b1;
   logic t1 = 1'b0, tx = 1'b0, tv = 1'b0, tr = 1'b0, td = 1'b0, t2 = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [4:0] tap, modc;
   logic [2:0] rsel;
   logic [9:0] mult;
   logic [1:0] drv, cap;
   logic men, x2e, x1e, xm, fb, rf, at, mt, st, pin;
   int err_count = 0, checks = 0, cyc = 0;
   int c[6];
   logic [15:0] rst[10] = '{RST_TAP_MOD, RST_RANGE, RST_LOOP_DIV, RST_LOOP_REF, RST_SRC_SEL,
      RST_DIV_SEL, RST_XTAL, RST_FAULT, RST_REQ_EN, RST_SWING};
   logic [15:0] wm[10] = '{WM_TAP_MOD, WM_RANGE, WM_LOOP_DIV, WM_LOOP_REF, WM_SRC_SEL,
      WM_DIV_SEL, WM_XTAL, WM_FAULT, WM_REQ_EN, WM_SWING};
   // Ticks in a 720 cycle window for each source code
   int rate[8] = '{240, 180, 90, 720, 360, 45, 45, 45};
   int rfr[8] = '{240, 240, 90, 90, 90, 45, 45, 45};
   int rdv[8] = '{1, 2, 4, 8, 12, 16, 16, 16};

   ucu_regs u_dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wr_en(wr_en),
      .rd_en(rd_en), .byte_en(byte_en), .wdata(wdata), .rdata(rdata), .loop_step_up(up),
      .loop_step_down(dn), .radio_asleep(asl), .xt1_tick(t1), .xt1_ext_tick(tx),
      .vlo_tick(tv), .ref_tick(tr), .dco_tick(td), .xt2_tick(t2), .osc_tap(tap),
      .modulation_counter(modc), .modulation_enable(men), .osc_range_select(rsel),
      .loop_multiplier(mult), .loop_fb_tick(fb), .loop_ref_tick(rf), .aux_tick(at),
      .main_tick(mt), .sub_tick(st), .aux_pin_out(pin), .xt2_enable(x2e),
      .xt1_internal_enable(x1e), .primary_crystal_drive(drv), .load_capacitor_apply(cap),
      .primary_crystal_mode(xm));

   // ------------------------------------------------------------
   // Clock and source ticks
   // ------------------------------------------------------------
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      t1 <= (cyc % 3 == 0);
      tx <= (cyc % 5 == 0);
      tv <= (cyc % 4 == 0);
      tr <= (cyc % 8 == 0);
      td <= 1'b1;
      t2 <= (cyc % 16 == 0);
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("Checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Divider phase is unknown at window start, so one tick of slack
   task automatic near(input string n, input int g, input int e);
      chk(n, (g >= e - 1 && g <= e + 1) ? 16'(e) : 16'(g), 16'(e));
   endtask : near

   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic b = 1'b0);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      byte_en <= b;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      @(negedge ref_clk);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic b, input logic [15:0] e, input string n);
      @(posedge ref_clk);
      addr <= a;
      byte_en <= b;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(negedge ref_clk);
      chk(n, rdata, e);
   endtask : rd

   task automatic step(input logic u);
      @(posedge ref_clk);
      up <= u;
      dn <= !u;
      @(posedge ref_clk);
      up <= 1'b0;
      dn <= 1'b0;
      @(negedge ref_clk);
   endtask : step

   task automatic count();
      logic p;
      c = '{default: 0};
      p = pin;
      repeat (720)
      begin
         @(negedge ref_clk);
         c[0] += int'(mt);
         c[1] += int'(st);
         c[2] += int'(at);
         c[3] += int'(fb);
         c[4] += int'(rf);
         c[5] += int'(pin != p);
         p = pin;
      end
   endtask : count

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 10; i++)
         rd(5'(2 * i), 1'b0, rst[i], "reset");
      rd(5'h14, 1'b0, 16'h0000, "unmapped");
      chk("range", 16'(rsel), 16'h0002);
      chk("mult", 16'(mult), 16'h001f);
      chk("mod_en", 16'(men), 16'h0001);
      chk("drive", 16'(drv), 16'h0003);
      chk("cap", 16'(cap), 16'h0003);
      chk("xt2_en", 16'(x2e), 16'h0000);
      chk("xt1_int", 16'(x1e), 16'h0001);
      @(posedge ref_clk);
      asl <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("xt2_en", 16'(x2e), 16'h0001);
      @(posedge ref_clk);
      asl <= 1'b1;
   endtask : t_reset

   task automatic t_rw();
      logic [15:0] ro;
      for (int i = 0; i < 10; i++)
         wr(5'(2 * i), 16'hffff);
      for (int i = 0; i < 10; i++)
      begin
         // Crystal bits 15:14 are not writable and keep their reset ones
         ro = (i == 7) ? RO_FAULT : (i == 8) ? RO_REQ_EN : 16'h0000;
         ro = (i == 6) ? (RST_XTAL & ~WM_XTAL) : ro;
         rd(5'(2 * i), 1'b0, wm[i] | ro, "ones");
         wr(5'(2 * i), 16'h0000);
         rd(5'(2 * i), 1'b0, ro | 16'(i == 2 || i == 7), "zeros");
      end
   endtask : t_rw

   task automatic t_byte();
      wr(5'h05, 16'h005a, 1'b1);
      wr(5'h04, 16'h0034, 1'b1);
      rd(5'h04, 1'b0, 16'h5234, "word");
      rd(5'h05, 1'b1, 16'h5200, "high");
      rd(5'h04, 1'b1, 16'h0034, "low");
      chk("mult", 16'(mult), 16'h0234);
   endtask : t_byte

   task automatic t_loop();
      wr(5'h00, 16'h05f8);
      step(1'b1);
      chk("tap", 16'(tap), 16'h0006);
      chk("mod", 16'(modc), 16'h0000);
      step(1'b0);
      chk("tap", 16'(tap), 16'h0005);
      chk("mod", 16'(modc), 16'h001f);
      wr(5'h02, 16'h0071);
      @(negedge ref_clk);
      chk("mod_en", 16'(men), 16'h0000);
      chk("range", 16'(rsel), 16'h0007);
      wr(5'h00, 16'h1f00);
      wr(5'h0e, 16'h0000);
      rd(5'h0e, 1'b0, 16'h0301, "fault");
      wr(5'h00, 16'h0500);
      wr(5'h0e, 16'h0000);
      rd(5'h0e, 1'b0, 16'h0300, "fault");
   endtask : t_loop

   task automatic t_clk();
      int k;
      wr(5'h0c, 16'h0000);
      wr(5'h0a, 16'h0000);
      wr(5'h04, 16'h201f);
      wr(5'h06, 16'h0014);
      for (int s = 0; s < 8; s++)
      begin
         wr(5'h08, {5'h00, 3'(s), 1'b0, 3'h4, 1'b0, 3'(s)});
         count();
         near("main", c[0], rate[s]);
         near("sub", c[1], 360);
         near("aux", c[2], rate[s]);
         near("pin", c[5], rate[s]);
      end
      near("fb", c[3], 180);
      near("ref", c[4], 20);
      wr(5'h08, 16'h0333);
      for (int d = 0; d < 8; d++)
      begin
         k = (d > 5) ? 5 : d;
         wr(5'h0a, {1'b0, 3'(d), 1'b0, 3'(d), 1'b0, 3'(d), 1'b0, 3'(d)});
         wr(5'h04, {1'b0, 3'(d), 12'h01f});
         wr(5'h06, {13'h0000, 3'(d)});
         count();
         near("main", c[0], 720 >> k);
         near("sub", c[1], 720 >> k);
         near("aux", c[2], 720 >> k);
         near("pin", c[5], 720 >> (2 * k));
         near("fb", c[3], 720 >> k);
         near("ref", c[4], 240 / rdv[d]);
      end
      wr(5'h0a, 16'h0000);
      for (int s = 0; s < 8; s++)
      begin
         wr(5'h06, {9'h000, 3'(s), 4'h0});
         count();
         near("ref", c[4], rfr[s]);
      end
      wr(5'h0c, 16'h0002);
      count();
      near("sub", c[1], 0);
      wr(5'h08, 16'h0000);
      wr(5'h0c, 16'h0030);
      count();
      near("main", c[0], 144);
      chk("mode", 16'(xm), 16'h0001);
      chk("cap", 16'(cap), 16'h0000);
      chk("xt1_int", 16'(x1e), 16'h0000);
      wr(5'h0c, 16'h00cc);
      chk("drive", 16'(drv), 16'h0003);
      chk("cap", 16'(cap), 16'h0003);
   endtask : t_clk

   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      t_reset();
      t_rw();
      t_byte();
      t_loop();
      t_clk();
      end_sim();
   end

   initial
   begin
      repeat (100000) @(posedge ref_clk);
      err_count++;
      end_sim();
   end
endmodule : tb_ucu_regs
